// ==== hdl/sfsr_sequencer.sv ====
// soft-reset, deep power-down and suspend sequencer of a serial flash
// assumes serial pins are asynchronous to clk and oversampled well above the serial rate
// Notes on behaviour
// - reset needs enable frame then reset frame
// - accepted reset aborts internal work, power-on state
// - accepted reset clears every volatile setting
// - commands ignored during reset recovery
// - fresh array reads back all ones
// - status starts zero except drive bit one
// - deep power-down reached within three microseconds
// - standby reached within twenty microseconds after release
`timescale 1ns/1ps
`default_nettype none

module sfsr_sequencer
    import sfsr_pkg::*;
#(
    parameter int unsigned RESET_ERASE_COUNT = RESET_ERASE_CYCLES,
    parameter int unsigned POWERUP_COUNT     = POWERUP_CYCLES
)
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // serial pins
    input  wire logic                    csN,
    input  wire logic                    sck,
    input  wire logic                    si,
    // array engine state
    input  wire logic                    writeInProgress,
    input  wire logic                    eraseActive,
    input  wire logic                    welClear,
    // volatile setting loads from the command decoder
    input  wire logic                    statusLoad,
    input  wire logic [STATUS_WIDTH-1:0] statusData,
    input  wire logic                    readParamLoad,
    input  wire logic [7:0]              readParamData,
    input  wire logic                    contReadLoad,
    input  wire logic [7:0]              contReadData,
    input  wire logic                    wrapLoad,
    input  wire logic [2:0]              wrapData,
    // volatile state
    output var  logic [STATUS_WIDTH-1:0] statusValue,
    output var  logic                    writeEnableLatch,
    output var  logic [1:0]              suspendFlags,
    output var  logic [7:0]              readParamBits,
    output var  logic [7:0]              contReadBits,
    output var  logic [2:0]              wrapSettingBits,
    output var  logic [7:0]              blankByte,
    // sequencing
    output var  logic                    abortOp,
    output var  logic                    deepPowerDown,
    output var  logic                    ready,
    output var  logic                    cmdIgnored
);

    typedef enum logic [2:0] {
        PWR_START,
        PWR_WAIT,
        IDLE,
        RECOVER,
        PD_ENTER,
        DEEP,
        WAKE
    } sfsr_mode_t;

    typedef struct packed {
        logic [1:0]              csSync;
        logic [1:0]              sckSync;
        logic [1:0]              siSync;
        logic                    csPrev;
        logic                    sckPrev;
        logic [7:0]              shift;
        logic [3:0]              bitCount;
        sfsr_mode_t              mode;
        logic                    resetArmed;
        logic                    write_enable_latch;
        logic [1:0]              sus;
        logic [STATUS_WIDTH-1:0] status;
        logic [7:0]              readParam;
        logic [7:0]              contRead;
        logic [2:0]              wrap;
        logic                    deep;
        logic                    ready;
        logic                    abort;
        logic                    ignored;
    } sfsr_state_t;

    sfsr_state_t st_reg;
    sfsr_state_t st_next;

    logic                   timerLoad;
    logic [TIMER_WIDTH-1:0] timerValue;
    logic                   timerDone;

    logic                   frameEnd;
    logic                   sckRise;
    logic                   exact8;

    sfsr_timer #(
        .WIDTH     (TIMER_WIDTH)
    ) intervalTimer (
        .clk       (clk),
        .rstn      (rstn),
        .load      (timerLoad),
        .loadValue (timerValue),
        .done      (timerDone)
    );

    always_comb
    begin
        st_next         = st_reg;
        timerLoad       = 1'b0;
        timerValue      = '0;
        st_next.abort   = 1'b0;
        st_next.ignored = 1'b0;

        // pins pass two flip-flops; edges are seen on the second stage
        st_next.csSync  = {st_reg.csSync[0], csN};
        st_next.sckSync = {st_reg.sckSync[0], sck};
        st_next.siSync  = {st_reg.siSync[0], si};
        st_next.csPrev  = st_reg.csSync[1];
        st_next.sckPrev = st_reg.sckSync[1];

        frameEnd = st_reg.csSync[1] && !st_reg.csPrev;
        sckRise  = st_reg.sckSync[1] && !st_reg.sckPrev && !st_reg.csSync[1];
        exact8   = (st_reg.bitCount == OPCODE_BITS);

        if (st_reg.csSync[1])
        begin
            st_next.bitCount = '0;
        end
        else if (sckRise)
        begin
            // keep the opcode once eight bits are in, so trailing clocks leave it intact
            if (st_reg.bitCount < OPCODE_BITS)
            begin
                st_next.shift = {st_reg.shift[6:0], st_reg.siSync[1]};
            end
            if (st_reg.bitCount != BITS_SATURATE)
            begin
                st_next.bitCount = st_reg.bitCount + 1'b1;
            end
        end

        // hardware side updates of volatile settings
        if (welClear)
        begin
            st_next.write_enable_latch = 1'b0;
        end
        if (statusLoad)
        begin
            st_next.status = statusData;
        end
        if (readParamLoad)
        begin
            st_next.readParam = readParamData;
        end
        if (contReadLoad)
        begin
            st_next.contRead = contReadData;
        end
        if (wrapLoad)
        begin
            st_next.wrap = wrapData;
        end

        case (st_reg.mode)
            PWR_START:
            begin
                timerLoad    = 1'b1;
                timerValue   = POWERUP_COUNT[TIMER_WIDTH-1:0];
                st_next.mode = PWR_WAIT;
            end
            PWR_WAIT:
            begin
                if (timerDone)
                begin
                    st_next.mode  = IDLE;
                    st_next.ready = 1'b1;
                end
            end
            IDLE:
            begin
                if (frameEnd && st_reg.bitCount >= OPCODE_BITS)
                begin
                    st_next.resetArmed = 1'b0;
                    if (exact8 && st_reg.shift == OP_RESET_ENABLE)
                    begin
                        st_next.resetArmed = 1'b1;
                    end
                    else if (exact8 && st_reg.shift == OP_RESET && st_reg.resetArmed)
                    begin
                        st_next.abort     = 1'b1;
                        st_next.write_enable_latch       = 1'b0;
                        st_next.sus       = 2'h0;
                        st_next.status    = STATUS_RESET;
                        st_next.readParam = READ_PARAM_RESET;
                        st_next.contRead  = CONT_READ_RESET;
                        st_next.wrap      = WRAP_RESET;
                        st_next.deep      = 1'b0;
                        st_next.ready     = 1'b0;
                        st_next.mode      = RECOVER;
                        timerLoad         = 1'b1;
                        timerValue        = eraseActive ? RESET_ERASE_COUNT[TIMER_WIDTH-1:0]
                                                        : RESET_CYCLES[TIMER_WIDTH-1:0];
                    end
                    else if (exact8 && st_reg.shift == OP_POWER_DOWN)
                    begin
                        st_next.ready = 1'b0;
                        st_next.mode  = PD_ENTER;
                        timerLoad     = 1'b1;
                        timerValue    = POWERDOWN_LOAD[TIMER_WIDTH-1:0];
                    end
                    else if (exact8 && st_reg.shift == OP_WRITE_ENABLE)
                    begin
                        st_next.write_enable_latch = 1'b1;
                    end
                    else if (exact8 && st_reg.shift == OP_WRITE_DISABLE)
                    begin
                        st_next.write_enable_latch = 1'b0;
                    end
                    else if (exact8 && st_reg.shift == OP_SUSPEND)
                    begin
                        if (writeInProgress && st_reg.sus == 2'h0)
                        begin
                            st_next.sus = eraseActive ? SUSPEND_ERASE : SUSPEND_PROGRAM;
                        end
                    end
                    else if (exact8 && st_reg.shift == OP_RESUME)
                    begin
                        if (!writeInProgress && st_reg.sus != 2'h0)
                        begin
                            st_next.sus = 2'h0;
                        end
                    end
                end
            end
            RECOVER:
            begin
                if (frameEnd)
                begin
                    st_next.ignored = 1'b1;
                end
                if (timerDone)
                begin
                    st_next.mode  = IDLE;
                    st_next.ready = 1'b1;
                end
            end
            PD_ENTER:
            begin
                if (frameEnd)
                begin
                    st_next.ignored = 1'b1;
                end
                if (timerDone)
                begin
                    st_next.deep = 1'b1;
                    st_next.mode = DEEP;
                end
            end
            DEEP:
            begin
                if (frameEnd && st_reg.bitCount >= OPCODE_BITS && st_reg.shift == OP_RELEASE)
                begin
                    st_next.mode = WAKE;
                    timerLoad    = 1'b1;
                    timerValue   = WAKE_LOAD[TIMER_WIDTH-1:0];
                end
                else if (frameEnd)
                begin
                    st_next.ignored = 1'b1;
                end
            end
            WAKE:
            begin
                if (frameEnd)
                begin
                    st_next.ignored = 1'b1;
                end
                if (timerDone)
                begin
                    st_next.deep  = 1'b0;
                    st_next.ready = 1'b1;
                    st_next.mode  = IDLE;
                end
            end
            default:
            begin
                st_next.mode = PWR_START;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_reg           <= '0;
            st_reg.csSync    <= 2'h3;
            st_reg.csPrev    <= 1'b1;
            st_reg.mode      <= PWR_START;
            st_reg.status    <= STATUS_RESET;
            st_reg.readParam <= READ_PARAM_RESET;
            st_reg.contRead  <= CONT_READ_RESET;
            st_reg.wrap      <= WRAP_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // fixed erased-cell value is held in its own flip-flop
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            blankByte <= BLANK_BYTE;
        end
        else
        begin
            blankByte <= BLANK_BYTE;
        end
    end

    assign statusValue      = st_reg.status;
    assign writeEnableLatch = st_reg.write_enable_latch;
    assign suspendFlags     = st_reg.sus;
    assign readParamBits    = st_reg.readParam;
    assign contReadBits     = st_reg.contRead;
    assign wrapSettingBits  = st_reg.wrap;
    assign abortOp          = st_reg.abort;
    assign deepPowerDown    = st_reg.deep;
    assign ready            = st_reg.ready;
    assign cmdIgnored       = st_reg.ignored;

endmodule // sfsr_sequencer

`default_nettype wire

// ==== hdl/sfsr_pkg.sv ====
// constants of the flash soft-reset and command-spacing sequencer
// assumes a 125 MHz system clock that oversamples the serial pins
package sfsr_pkg;

    // system clock period
    localparam int unsigned CLK_PERIOD_NS      = 8;

    // opcodes seen by the sequencer
    localparam logic [7:0]  OP_RESET_ENABLE    = 8'h66;
    localparam logic [7:0]  OP_RESET           = 8'h99;
    localparam logic [7:0]  OP_POWER_DOWN      = 8'hb9;
    localparam logic [7:0]  OP_RELEASE        = 8'hab;
    localparam logic [7:0]  OP_SUSPEND         = 8'h75;
    localparam logic [7:0]  OP_RESUME          = 8'h7a;
    localparam logic [7:0]  OP_WRITE_ENABLE    = 8'h06;
    localparam logic [7:0]  OP_WRITE_DISABLE   = 8'h04;
    localparam logic [7:0]  OP_PLAIN_READ      = 8'h03;

    // frame length of a bare opcode
    localparam logic [3:0]  OPCODE_BITS        = 4'h8;
    localparam logic [3:0]  BITS_SATURATE      = 4'h9;

    // delivery and power-on values
    localparam int          STATUS_WIDTH       = 24;
    localparam int          DRIVE_LSB_POS      = 21;
    localparam logic [23:0] STATUS_RESET       = 24'h200000;
    localparam logic [7:0]  BLANK_BYTE         = 8'hff;
    localparam logic [7:0]  READ_PARAM_RESET   = 8'h00;
    localparam logic [7:0]  CONT_READ_RESET    = 8'h00;
    localparam logic [2:0]  WRAP_RESET         = 3'h0;
    localparam logic [1:0]  SUSPEND_PROGRAM    = 2'h1;
    localparam logic [1:0]  SUSPEND_ERASE      = 2'h2;

    // times in their own units
    localparam int unsigned POWERDOWN_ENTRY_US = 3;
    localparam int unsigned WAKE_TIME_US       = 20;
    localparam int unsigned RESET_RECOVER_US   = 30;
    localparam int unsigned RESET_ERASE_MS     = 12;
    localparam int unsigned POWERUP_DELAY_US10 = 18000;  // 1.8 ms in tenths of a microsecond

    // cycle counts; longest times round down
    localparam int unsigned POWERDOWN_CYCLES   = (POWERDOWN_ENTRY_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_CYCLES        = (WAKE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned RESET_CYCLES       = (RESET_RECOVER_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned RESET_ERASE_CYCLES = (RESET_ERASE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned POWERUP_CYCLES     = (POWERUP_DELAY_US10 * 100) / CLK_PERIOD_NS;

    // pin sync, edge detect and decode eat this much of a deadline counted from the pin
    localparam int unsigned PIN_LATENCY_CYCLES = 4;
    localparam int unsigned POWERDOWN_LOAD     = POWERDOWN_CYCLES - PIN_LATENCY_CYCLES;
    localparam int unsigned WAKE_LOAD          = WAKE_CYCLES - PIN_LATENCY_CYCLES;

    // width of the shared interval timer
    localparam int          TIMER_WIDTH        = 24;

endpackage

// ==== hdl/sfsr_timer.sv ====
// one-shot down counter for the sequencer's waiting intervals
// assumes load is a single-cycle request from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module sfsr_timer
    import sfsr_pkg::*;
#(
    parameter int WIDTH = TIMER_WIDTH
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    // status
    output var  logic             done
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             done;
    } sfsr_timer_state_t;

    sfsr_timer_state_t st_reg;
    sfsr_timer_state_t st_next;

    always_comb
    begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (load)
        begin
            st_next.count = loadValue;
        end
        else if (st_reg.count != '0)
        begin
            st_next.count = st_reg.count - 1'b1;
            // pulse as the count reaches zero
            st_next.done  = (st_reg.count == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign done = st_reg.done;

endmodule // sfsr_timer

`default_nettype wire

// ==== testbench/sfsr_checker.sv ====
// concurrent checks on the soft-reset sequencer outputs
// assumes it is bound into sfsr_sequencer and shares its clock
`timescale 1ns/1ps
`default_nettype none

module sfsr_checker
    import sfsr_pkg::*;
#(
    parameter int unsigned RESET_ERASE_COUNT = RESET_ERASE_CYCLES
)
(
    // clock and reset
    input wire logic                    clk,
    input wire logic                    rstn,
    // engine state
    input wire logic                    eraseActive,
    // volatile state
    input wire logic [STATUS_WIDTH-1:0] statusValue,
    input wire logic                    writeEnableLatch,
    input wire logic [1:0]              suspendFlags,
    input wire logic [7:0]              readParamBits,
    input wire logic [7:0]              contReadBits,
    input wire logic [2:0]              wrapSettingBits,
    input wire logic [7:0]              blankByte,
    // sequencing
    input wire logic                    abortOp,
    input wire logic                    deepPowerDown,
    input wire logic                    ready,
    input wire logic                    cmdIgnored
);
    localparam int recLo = RESET_CYCLES - 1;
    localparam int recHi = RESET_CYCLES + 3;
    localparam int eraLo = RESET_ERASE_COUNT - 1;
    localparam int eraHi = RESET_ERASE_COUNT + 3;
    logic [23:0] recCnt_reg;
    logic        erFlag_reg;

    // cycles since an accepted reset while the device stays busy
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            recCnt_reg <= 24'h0;
            erFlag_reg <= 1'b0;
        end
        else if (abortOp)
        begin
            recCnt_reg <= 24'h1;
            erFlag_reg <= eraseActive;
        end
        else if (ready)
        begin
            recCnt_reg <= 24'h0;
        end
        else if (recCnt_reg != 24'h0)
        begin
            recCnt_reg <= recCnt_reg + 24'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_abort_drops_ready: assert property (abortOp |-> !ready) else $error("ready high at reset");
    a_abort_clears_state: assert property (abortOp |-> statusValue == STATUS_RESET && !writeEnableLatch
        && suspendFlags == 2'h0 && readParamBits == READ_PARAM_RESET && contReadBits == CONT_READ_RESET
        && wrapSettingBits == WRAP_RESET && !deepPowerDown) else $error("volatile state kept over reset");
    a_abort_single_pulse: assert property (abortOp |=> !abortOp) else $error("abort longer than a cycle");
    a_blank_constant: assert property (blankByte == BLANK_BYTE) else $error("blank byte wrong");
    a_status_after_reset: assert property ($rose(rstn) |-> statusValue == STATUS_RESET && !ready)
        else $error("status wrong after reset");
    a_recovery_time: assert property ($rose(ready) && recCnt_reg != 24'h0 |-> (erFlag_reg ?
        (recCnt_reg >= eraLo && recCnt_reg <= eraHi) : (recCnt_reg >= recLo && recCnt_reg <= recHi)))
        else $error("reset recovery length wrong");
    a_ignore_when_busy: assert property (cmdIgnored |-> !ready) else $error("ignored while ready");
    a_deep_not_ready: assert property (deepPowerDown |-> !ready && !abortOp) else $error("ready in deep");
    a_wake_to_ready: assert property ($fell(deepPowerDown) && $past(rstn) |-> ready)
        else $error("no standby after wake");

    c_reset: cover property (abortOp);
    c_deep: cover property ($rose(deepPowerDown));
    c_ignored: cover property (cmdIgnored);
endmodule // sfsr_checker

bind sfsr_sequencer sfsr_checker #(.RESET_ERASE_COUNT(RESET_ERASE_COUNT)) chk (.clk(clk), .rstn(rstn),
    .eraseActive(eraseActive), .statusValue(statusValue), .writeEnableLatch(writeEnableLatch),
    .suspendFlags(suspendFlags), .readParamBits(readParamBits), .contReadBits(contReadBits),
    .wrapSettingBits(wrapSettingBits), .blankByte(blankByte), .abortOp(abortOp),
    .deepPowerDown(deepPowerDown), .ready(ready), .cmdIgnored(cmdIgnored));
`default_nettype wire

// ==== testbench/sfsr_host.sv ====
// host controller model driving chip select, serial clock and data
// assumes clk is the bench clock; sck stands low outside frames
`timescale 1ns/1ps
`default_nettype none

module sfsr_host
(
    // clock
    input  wire logic clk,
    // serial pins toward the device
    output var  logic csN,
    output var  logic sck,
    output var  logic si
);
    initial
    begin
        csN = 1'b1;
        sck = 1'b0;
        si  = 1'b0;
    end

    // one opcode frame, msb first, then extra trailing clocks; each phase four cycles (about 15.6 MHz)
    task automatic send(input logic [7:0] op, input int extra = 0);
        int i;
        logic [7:0] sh;
        sh = op;
        @(posedge clk);
        #1 csN = 1'b0;
        for (i = 0; i < 8 + extra; i++)
        begin
            si = sh[7];
            sh = {sh[6:0], 1'b0};
            repeat (4) @(posedge clk);
            #1 sck = 1'b1;
            repeat (4) @(posedge clk);
            #1 sck = 1'b0;
        end
        repeat (4) @(posedge clk);
        #1 csN = 1'b1;
        si = ~si;
        repeat (8) @(posedge clk);
        #1;
    endtask
endmodule // sfsr_host
`default_nettype wire

// ==== testbench/sfsr_sequencer_tb.sv ====
// self-checking bench for the soft-reset sequencer
// assumes sfsr_host drives the serial pins and the checker is bound
`timescale 1ns/1ps
`default_nettype none

module sfsr_sequencer_tb;
    import sfsr_pkg::*;
    localparam int unsigned ERA = 20;
    logic        clk = 1'b0, rstn = 1'b0, write_in_progress_flag = 1'b0, era = 1'b0, welClr = 1'b0;
    logic        stLd = 1'b0, rpLd = 1'b0, crLd = 1'b0, wrLd = 1'b0;
    logic [23:0] stD = 24'h0;
    logic [7:0]  rpD = 8'h0, crD = 8'h0;
    logic [2:0]  wrD = 3'h0;
    wire logic   csN, sck, si;
    logic [23:0] statusValue;
    logic [7:0]  readParamBits, contReadBits, blankByte;
    logic [2:0]  wrapSettingBits;
    logic [1:0]  suspendFlags;
    logic        writeEnableLatch, abortOp, deepPowerDown, ready, cmdIgnored;
    int          err_count = 0, checks_done = 0, cyc = 0, abortAt = 0, abortSeen = 0, ignSeen = 0, n;

    always #4 clk = ~clk;

    sfsr_host host (.clk(clk), .csN(csN), .sck(sck), .si(si));
    sfsr_sequencer #(.RESET_ERASE_COUNT(ERA), .POWERUP_COUNT(10)) uut (.clk(clk), .rstn(rstn), .csN(csN),
        .sck(sck), .si(si), .writeInProgress(write_in_progress_flag), .eraseActive(era), .welClear(welClr), .statusLoad(stLd),
        .statusData(stD), .readParamLoad(rpLd), .readParamData(rpD), .contReadLoad(crLd), .contReadData(crD),
        .wrapLoad(wrLd), .wrapData(wrD), .statusValue(statusValue), .writeEnableLatch(writeEnableLatch),
        .suspendFlags(suspendFlags), .readParamBits(readParamBits), .contReadBits(contReadBits),
        .wrapSettingBits(wrapSettingBits), .blankByte(blankByte), .abortOp(abortOp),
        .deepPowerDown(deepPowerDown), .ready(ready), .cmdIgnored(cmdIgnored));

    // one-cycle pulses are counted where they stand
    always @(posedge clk)
    begin
        cyc++;
        if (abortOp === 1'b1)
        begin
            abortSeen++;
            abortAt = cyc;
        end
        if (cmdIgnored === 1'b1)
            ignSeen++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic wait_for(input bit deep, input logic lvl, input int max, output int k);
        for (k = 0; k < max && (deep ? deepPowerDown : ready) !== lvl; k++)
            tick(1);
        chk(deep ? deepPowerDown : ready, lvl);
    endtask

    task automatic load_all;
        {stLd, rpLd, crLd, wrLd} = 4'hf;
        stD = 24'h0f00f0;
        rpD = 8'h5a;
        crD = 8'ha5;
        wrD = 3'h5;
        tick(1);
        {stLd, rpLd, crLd, wrLd} = 4'h0;
        tick(1);
        chk(statusValue, 24'h0f00f0);
        chk({readParamBits, contReadBits, wrapSettingBits}, {8'h5a, 8'ha5, 3'h5});
    endtask

    task automatic chk_clear;
        chk(statusValue, STATUS_RESET);
        chk({writeEnableLatch, suspendFlags, readParamBits, contReadBits, wrapSettingBits, deepPowerDown}, 0);
    endtask

    task automatic reset_seq;
        host.send(OP_RESET_ENABLE);
        host.send(OP_RESET);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #400000;
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        tick(10);
        rstn = 1'b1;
        tick(1);
        chk_clear();
        chk(blankByte, BLANK_BYTE);
        wait_for(0, 1'b1, 40, n);
        load_all();
        host.send(OP_WRITE_ENABLE);
        chk(writeEnableLatch, 1'b1);
        host.send(OP_RESET_ENABLE);
        host.send(OP_WRITE_ENABLE);
        host.send(OP_RESET);
        chk(abortSeen, 0);
        chk(writeEnableLatch, 1'b1);
        welClr = 1'b1;
        tick(1);
        welClr = 1'b0;
        tick(1);
        chk(writeEnableLatch, 1'b0);
        write_in_progress_flag = 1'b1;
        host.send(OP_SUSPEND);
        write_in_progress_flag = 1'b0;
        chk(suspendFlags, SUSPEND_PROGRAM);
        tick(WAKE_CYCLES);
        host.send(OP_RESUME);
        chk(suspendFlags, 2'h0);
        tick(12500);
        write_in_progress_flag = 1'b1;
        era = 1'b1;
        host.send(OP_SUSPEND);
        write_in_progress_flag = 1'b0;
        chk(suspendFlags, SUSPEND_ERASE);
        tick(WAKE_CYCLES);
        load_all();
        reset_seq();
        chk(abortSeen, 1);
        chk(ready, 1'b0);
        chk_clear();
        wait_for(0, 1'b1, ERA + 10, n);
        chk((cyc - abortAt) >= ERA && (cyc - abortAt) <= ERA + 3, 1'b1);
        era = 1'b0;
        load_all();
        host.send(OP_WRITE_ENABLE);
        reset_seq();
        chk(abortSeen, 2);
        chk_clear();
        host.send(OP_WRITE_ENABLE);
        chk(ignSeen, 1);
        chk(writeEnableLatch, 1'b0);
        wait_for(0, 1'b1, RESET_CYCLES + 10, n);
        chk((cyc - abortAt) >= RESET_CYCLES && (cyc - abortAt) <= RESET_CYCLES + 3, 1'b1);
        host.send(OP_POWER_DOWN);
        wait_for(1, 1'b1, POWERDOWN_CYCLES + 10, n);
        chk(n + 8 <= POWERDOWN_CYCLES, 1'b1);
        host.send(OP_WRITE_ENABLE);
        chk(ignSeen, 2);
        chk(writeEnableLatch, 1'b0);
        host.send(OP_RELEASE);
        wait_for(1, 1'b0, WAKE_CYCLES + 10, n);
        chk(n + 8 <= WAKE_CYCLES, 1'b1);
        chk(ready, 1'b1);
        host.send(OP_POWER_DOWN);
        wait_for(1, 1'b1, POWERDOWN_CYCLES + 10, n);
        host.send(OP_RELEASE, 32);
        wait_for(1, 1'b0, WAKE_CYCLES + 10, n);
        chk(n + 8 <= WAKE_CYCLES, 1'b1);
        chk(ready, 1'b1);
        tally_and_finish();
    end
endmodule // sfsr_sequencer_tb
`default_nettype wire
